// [hw/mrb_cal_ser.sv]
`timescale 1ns/1ps
module mrb_cal_ser
    import mrb_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_sync_b,
    input wire logic start,
    input wire logic [7:0] pat_a,
    input wire logic [7:0] pat_b,
    input wire logic [7:0] inv_lo,
    input wire logic [7:0] inv_hi,
    output logic [15:0] dq,
    output logic [1:0] dmi,
    output logic busy
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [15:0] shift;
        logic [4:0] cnt;
        logic [15:0] dq;
        logic [1:0] dmi;
        logic busy;
    } mrb_ser_t;
    mrb_ser_t s_q, s_d;
    // Next state: A then B, low bit first
    always_comb begin
        s_d = s_q;
        if (start) begin
            s_d.shift = {pat_b, pat_a};
            s_d.cnt = 5'(CAL_BITS);
            s_d.busy = 1'b1;
        end else if (s_q.cnt != 5'h00) begin
            // Per-lane inversion, never on mask pins, no BUS_INVERSION
            s_d.dq = {{4{s_q.shift[0]}} ^ inv_hi[7:4], {4{s_q.shift[0]}} ^ inv_hi[3:0],
                {4{s_q.shift[0]}} ^ inv_lo[7:4], {4{s_q.shift[0]}} ^ inv_lo[3:0]};
            s_d.dmi = {2{s_q.shift[0]}};
            s_d.shift = {1'b0, s_q.shift[15:1]};
            s_d.cnt = s_q.cnt - 5'h01;
            s_d.busy = 1'b1;
        end else begin
            s_d.busy = 1'b0;
        end
    end
    // Register
    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign dq = s_q.dq;
    assign dmi = s_q.dmi;
    assign busy = s_q.busy;
    // Mask pins equal the uninverted pattern bit carried by an 00h mask lane
    property p_dmi_true;
        @(posedge mclk) disable iff (!rst_sync_b)
        (s_q.cnt != 5'h00 && !start) |=> (dmi[0] == $past(s_q.shift[0]) && dmi[1] == dmi[0]);
    endproperty
    a_dmi_true: assert property (p_dmi_true) else $error("mask pin inverted");
    property p_lane_inv;
        @(posedge mclk) disable iff (!rst_sync_b)
        (s_q.cnt != 5'h00 && !start) |=> (dq[0] == ($past(s_q.shift[0]) ^ $past(inv_lo[0])))
            && (dq[8] == ($past(s_q.shift[0]) ^ $past(inv_hi[0])));
    endproperty
    a_lane_inv: assert property (p_lane_inv) else $error("lane inversion wrong");
    property p_len;
        @(posedge mclk) disable iff (!rst_sync_b)
        start |=> busy [*8] ##0 (s_q.cnt == 5'd9);
    endproperty
    a_len: assert property (p_len) else $error("serial length wrong");
endmodule

// [hw/mrb_pkg.sv]
package mrb_pkg;
    // ----------------------------------------
    // Register addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_IO_CONFIG = 8'h03;
    localparam logic [7:0] ADDR_TERM_VALUE = 8'h0B;
    localparam logic [7:0] ADDR_CA_REF = 8'h0C;
    localparam logic [7:0] ADDR_SET_POINT = 8'h0D;
    localparam logic [7:0] ADDR_DQ_REF = 8'h0E;
    localparam logic [7:0] ADDR_LOWER_INV = 8'h0F;
    localparam logic [7:0] ADDR_BANK_MASK = 8'h10;
    localparam logic [7:0] ADDR_SEG_MASK = 8'h11;
    localparam logic [7:0] ADDR_OSC_LOW = 8'h12;
    localparam logic [7:0] ADDR_OSC_HIGH = 8'h13;
    localparam logic [7:0] ADDR_UPPER_INV = 8'h14;
    localparam logic [7:0] ADDR_RSVD_21 = 8'h15;
    localparam logic [7:0] ADDR_TERM_OVR = 8'h16;
    localparam logic [7:0] ADDR_PAT_A = 8'h20;
    localparam logic [7:0] ADDR_PAT_B = 8'h28;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] RST_INV = 8'h55;
    localparam logic [7:0] RST_PAT_A = 8'h5A;
    localparam logic [7:0] RST_PAT_B = 8'h3C;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [6:0] RST_REF = 7'h4D;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BIT_RD_DBI = 6;
    localparam int BIT_WRITE_SET_POINT_SELECT = 6;
    localparam int BIT_OPERATING_SET_POINT_SELECT = 7;
    localparam int BIT_CK_FORCE = 3;
    localparam int BIT_CS_FORCE = 4;
    localparam int BIT_CA_DIS = 5;
    localparam int CAL_BITS = 16;
    localparam logic [2:0] CONTROLLER_TERMINATION_VALUE_RSVD = 3'h7;
    // Register access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] data;
    } mrb_req_t;
    // Termination status outputs
    typedef struct packed {
        logic ck_on;
        logic cs_on;
        logic ca_on;
        logic [2:0] ctrl_div;
        logic ctrl_en;
    } mrb_term_t;
endpackage

// [hw/mrb_top.sv]
`timescale 1ns/1ps
module mrb_top
    import mrb_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire mrb_req_t req,
    input wire logic osc_start,
    input wire logic [15:0] osc_count,
    input wire logic osc_valid,
    input wire logic cal_start,
    input wire logic ca_term_pad,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic [7:0] bank_mask_ch0,
    output logic [7:0] bank_mask_ch1,
    output logic [7:0] seg_mask_ch0,
    output logic [7:0] seg_mask_ch1,
    input wire logic ch_sel,
    output mrb_term_t term,
    output logic [6:0] ca_ref_active,
    output logic [6:0] dq_ref_active,
    output logic rd_dbi_en,
    output logic [15:0] cal_dq,
    output logic [1:0] cal_dmi,
    output logic cal_busy
);
    // ----------------------------------------
    // Reset synchroniser
    // ----------------------------------------
    logic rst_m_q, rst_sync_q;
    // Two-stage release of reset
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_m_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_sync_q <= rst_m_q;
        end
    end
    // ----------------------------------------
    // Register state
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] io_cfg;
        logic [7:0] set_pt;
        logic [1:0][7:0] term_val;
        logic [1:0][6:0] ca_ref;
        logic [1:0][6:0] dq_ref;
        logic [1:0][5:0] ovr;
        logic [7:0] inv_lo;
        logic [7:0] inv_hi;
        logic [1:0][7:0] bank;
        logic [1:0][7:0] seg;
        logic [15:0] osc;
        logic [7:0] pat_a;
        logic [7:0] pat_b;
        logic [7:0] rd_data;
        logic rd_valid;
        mrb_term_t term;
        logic [6:0] ca_act;
        logic [6:0] dq_act;
    } mrb_state_t;
    mrb_state_t r_q, r_d;
    logic wsp, osp;
    // Decode of the controller termination code
    function automatic logic controller_termination_value_enabled(input logic [2:0] code);
        controller_termination_value_enabled = (code != 3'h0) && (code != CONTROLLER_TERMINATION_VALUE_RSVD);
    endfunction
    // Next-state logic
    always_comb begin
        r_d = r_q;
        wsp = r_q.set_pt[BIT_WRITE_SET_POINT_SELECT];
        osp = r_q.set_pt[BIT_OPERATING_SET_POINT_SELECT];
        r_d.rd_valid = 1'b0;
        // Writes, 8-bit data at 8-bit address
        if (req.wr) begin
            case (req.addr)
                ADDR_IO_CONFIG: r_d.io_cfg = req.data;
                ADDR_SET_POINT: r_d.set_pt = req.data;
                ADDR_TERM_VALUE: r_d.term_val[wsp] = req.data;
                ADDR_CA_REF: r_d.ca_ref[wsp] = req.data[6:0];
                ADDR_DQ_REF: r_d.dq_ref[wsp] = req.data[6:0];
                ADDR_LOWER_INV: r_d.inv_lo = req.data;
                ADDR_UPPER_INV: r_d.inv_hi = req.data;
                ADDR_BANK_MASK: r_d.bank[ch_sel] = req.data;
                ADDR_SEG_MASK: r_d.seg[ch_sel] = req.data;
                ADDR_TERM_OVR: r_d.ovr[wsp] = req.data[5:0];
                ADDR_PAT_A: r_d.pat_a = req.data;
                ADDR_PAT_B: r_d.pat_b = req.data;
                default: r_d.rd_valid = 1'b0;
            endcase
        end
        // Reads; unmapped and reserved return zero
        if (req.rd) begin
            r_d.rd_valid = 1'b1;
            case (req.addr)
                ADDR_IO_CONFIG: r_d.rd_data = r_q.io_cfg;
                ADDR_SET_POINT: r_d.rd_data = r_q.set_pt;
                ADDR_TERM_VALUE: r_d.rd_data = r_q.term_val[wsp];
                ADDR_CA_REF: r_d.rd_data = {1'b0, r_q.ca_ref[wsp]};
                ADDR_DQ_REF: r_d.rd_data = {1'b0, r_q.dq_ref[wsp]};
                ADDR_OSC_LOW: r_d.rd_data = r_q.osc[7:0];
                ADDR_OSC_HIGH: r_d.rd_data = r_q.osc[15:8];
                ADDR_PAT_A: r_d.rd_data = r_q.pat_a;
                ADDR_TERM_OVR: r_d.rd_data = {2'b00, r_q.ovr[wsp]};
                default: r_d.rd_data = RST_ZERO;
            endcase
        end
        // Oscillator count: start clears, which wins over a result
        if (osc_start) begin
            r_d.osc = 16'h0000;
        end else if (osc_valid) begin
            r_d.osc = osc_count;
        end
        // Termination from the operating copy only
        r_d.term.ctrl_div = r_q.ovr[osp][2:0];
        r_d.term.ctrl_en = controller_termination_value_enabled(r_q.ovr[osp][2:0]);
        r_d.term.ck_on = r_q.ovr[osp][BIT_CK_FORCE] ? (r_q.term_val[osp][6:4] != 3'h0)
            : (ca_term_pad && r_q.term_val[osp][6:4] != 3'h0);
        r_d.term.cs_on = r_q.ovr[osp][BIT_CS_FORCE] ? (r_q.term_val[osp][6:4] != 3'h0)
            : (ca_term_pad && r_q.term_val[osp][6:4] != 3'h0);
        r_d.term.ca_on = !r_q.ovr[osp][BIT_CA_DIS] && ca_term_pad
            && (r_q.term_val[osp][6:4] != 3'h0);
        r_d.ca_act = r_q.ca_ref[osp];
        r_d.dq_act = r_q.dq_ref[osp];
    end
    // State register with documented reset values
    always_ff @(posedge mclk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            r_q <= '0;
            r_q.inv_lo <= RST_INV;
            r_q.inv_hi <= RST_INV;
            r_q.pat_a <= RST_PAT_A;
            r_q.pat_b <= RST_PAT_B;
            r_q.ca_ref <= {RST_REF, RST_REF};
            r_q.dq_ref <= {RST_REF, RST_REF};
        end else begin
            r_q <= r_d;
        end
    end
    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign rd_data = r_q.rd_data;
    assign rd_valid = r_q.rd_valid;
    assign bank_mask_ch0 = r_q.bank[0];
    assign bank_mask_ch1 = r_q.bank[1];
    assign seg_mask_ch0 = r_q.seg[0];
    assign seg_mask_ch1 = r_q.seg[1];
    assign term = r_q.term;
    assign ca_ref_active = r_q.ca_act;
    assign dq_ref_active = r_q.dq_act;
    assign rd_dbi_en = r_q.io_cfg[BIT_RD_DBI];
    // Calibration serialiser ignores the read BUS_INVERSION enable
    mrb_cal_ser u_ser (
        .mclk(mclk),
        .rst_sync_b(rst_sync_q),
        .start(cal_start),
        .pat_a(r_q.pat_a),
        .pat_b(r_q.pat_b),
        .inv_lo(r_q.inv_lo),
        .inv_hi(r_q.inv_hi),
        .dq(cal_dq),
        .dmi(cal_dmi),
        .busy(cal_busy)
    );
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_osc_clr;
        @(posedge mclk) disable iff (!rst_sync_q)
        osc_start |=> (r_q.osc == 16'h0000);
    endproperty
    a_osc_clr: assert property (p_osc_clr) else $error("count not cleared");
    property p_rsvd_zero;
        @(posedge mclk) disable iff (!rst_sync_q)
        (req.rd && req.addr == ADDR_RSVD_21) |=> (rd_valid && rd_data == 8'h00);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved read nonzero");
    property p_wr_copy;
        @(posedge mclk) disable iff (!rst_sync_q)
        (req.wr && req.addr == ADDR_TERM_OVR && !req.rd) |=>
            (r_q.ovr[$past(r_q.set_pt[BIT_WRITE_SET_POINT_SELECT])] == $past(req.data[5:0]));
    endproperty
    a_wr_copy: assert property (p_wr_copy) else $error("wrong set point copy");
    property p_ca_dis;
        @(posedge mclk) disable iff (!rst_sync_q)
        r_q.ovr[r_q.set_pt[BIT_OPERATING_SET_POINT_SELECT]][BIT_CA_DIS] |=> !term.ca_on;
    endproperty
    a_ca_dis: assert property (p_ca_dis) else $error("CA terminated while disabled");
    property p_osc_split;
        @(posedge mclk) disable iff (!rst_sync_q)
        (req.rd && req.addr == ADDR_OSC_HIGH) |=> (rd_data == $past(r_q.osc[15:8]));
    endproperty
    a_osc_split: assert property (p_osc_split) else $error("high byte wrong");
endmodule

// [sim/dram_mode_regs_cal_partial_array_refresh_odt_test.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Mode register bank testbench
// ----------------------------------------
module dram_mode_regs_cal_partial_array_refresh_odt_test;
    import mrb_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    mrb_req_t req;
    logic osc_start, osc_valid, cal_start, ca_term_pad, ch_sel, rd_valid, rd_dbi_en, cal_busy;
    logic [15:0] osc_count, cal_dq, v;
    logic [7:0] rd_data, bank_mask_ch0, bank_mask_ch1, seg_mask_ch0, seg_mask_ch1;
    logic [6:0] ca_ref_active, dq_ref_active;
    logic [1:0] cal_dmi;
    logic [8:0] r;
    mrb_term_t term;
    int errors = 0;
    int cmp_count = 0;
    // Addresses that read back as zero
    logic [7:0] zero_rd [7] = '{8'h0F, 8'h10, 8'h11, 8'h14, 8'h15, 8'h16, 8'h28};
    // Clock, 50 ns period
    always #25 mclk = ~mclk;
    mrb_top i_dut (.mclk(mclk), .rst_b(rst_b), .req(req), .osc_start(osc_start),
        .osc_count(osc_count), .osc_valid(osc_valid), .cal_start(cal_start),
        .ca_term_pad(ca_term_pad), .rd_data(rd_data), .rd_valid(rd_valid),
        .bank_mask_ch0(bank_mask_ch0), .bank_mask_ch1(bank_mask_ch1),
        .seg_mask_ch0(seg_mask_ch0), .seg_mask_ch1(seg_mask_ch1), .ch_sel(ch_sel),
        .term(term), .ca_ref_active(ca_ref_active), .dq_ref_active(dq_ref_active),
        .rd_dbi_en(rd_dbi_en), .cal_dq(cal_dq), .cal_dmi(cal_dmi), .cal_busy(cal_busy));
    mrb_ctrl_model i_ctrl (.mclk(mclk), .rd_data(rd_data), .rd_valid(rd_valid), .req(req),
        .osc_start(osc_start), .osc_count(osc_count), .osc_valid(osc_valid),
        .cal_start(cal_start), .ca_term_pad(ca_term_pad), .ch_sel(ch_sel));
    // Value compare
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // Register read compare, valid flag included
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        i_ctrl.mr_read(a, r);
        chk("read", {23'h0, 1'b1, e}, {23'h0, r});
    endtask
    // Termination and active reference compare after settling
    task automatic term_chk(input logic [6:0] e, input logic [6:0] ca);
        repeat (2) @(posedge mclk);
        #1;
        chk("term", {e, ca}, {term, ca_ref_active});
    endtask
    // Calibration stream: A then B, low bit first, DQ pins inverted by mask, DMI pins not
    task automatic cal_chk(input logic [7:0] pa, input logic [7:0] pb, input logic [15:0] inv);
        logic [15:0] s;
        s = {pb, pa};
        i_ctrl.pulse(1'b1);
        for (int i = 0; i < 16; i++) begin
            @(posedge mclk);
            #1;
            chk("cal_dq", {16{s[i]}} ^ inv, cal_dq);
            chk("cal_dmi_busy", {{2{s[i]}}, 1'b1}, {cal_dmi, cal_busy});
        end
    endtask
    // Verdict and end of run
    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Watchdog, far beyond the fewer than two hundred cycles needed
    initial begin
        #100us;
        errors++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        chk("masks", 32'h0, {bank_mask_ch0, seg_mask_ch0, bank_mask_ch1, seg_mask_ch1});
        chk("refs", {9'h0, 7'h4D, 7'h4D, 1'b0}, {9'h0, ca_ref_active, dq_ref_active, rd_dbi_en});
        chk("term", 32'h0, {25'h0, term});
        foreach (zero_rd[k]) rd_chk(zero_rd[k], 8'h00);
        cal_chk(8'h5A, 8'h3C, 16'h5555);
        i_ctrl.mr_write(ADDR_RSVD_21, 8'hFF);
        rd_chk(ADDR_RSVD_21, 8'h00);
        // New patterns, masks and read inversion enabled
        i_ctrl.mr_write(ADDR_IO_CONFIG, 8'h40);
        i_ctrl.mr_write(ADDR_PAT_A, 8'h1C);
        i_ctrl.mr_write(ADDR_PAT_B, 8'h59);
        i_ctrl.mr_write(ADDR_LOWER_INV, 8'h15);
        i_ctrl.mr_write(ADDR_UPPER_INV, 8'hA3);
        chk("dbi", 32'h1, {31'h0, rd_dbi_en});
        cal_chk(8'h1C, 8'h59, 16'hA315);
        // Per-channel refresh masks, segment bits 7:6 kept low
        i_ctrl.set_pins(1'b0, 1'b0);
        i_ctrl.mr_write(ADDR_BANK_MASK, 8'h81);
        i_ctrl.mr_write(ADDR_SEG_MASK, 8'h3C);
        i_ctrl.set_pins(1'b1, 1'b0);
        i_ctrl.mr_write(ADDR_BANK_MASK, 8'h7E);
        i_ctrl.mr_write(ADDR_SEG_MASK, 8'h05);
        @(posedge mclk);
        #1;
        chk("masks", 32'h813C7E05,
            {bank_mask_ch0, seg_mask_ch0, bank_mask_ch1, seg_mask_ch1});
        // Oscillator count load, read in two bytes, cleared by start
        i_ctrl.osc_load(16'hA51C);
        i_ctrl.osc_read(v);
        chk("osc", 32'hA51C, {16'h0, v});
        i_ctrl.pulse(1'b0);
        i_ctrl.osc_read(v);
        chk("osc", 32'h0, {16'h0, v});
        // Termination overrides on set point 0
        i_ctrl.mr_write(ADDR_TERM_VALUE, 8'h20);
        i_ctrl.mr_write(ADDR_CA_REF, 8'h65);
        i_ctrl.mr_write(ADDR_TERM_OVR, 8'h0B);
        term_chk(7'b1000111, 7'h65);
        i_ctrl.set_pins(1'b0, 1'b1);
        term_chk(7'b1110111, 7'h65);
        // Pad low again so only the select force keeps termination on
        i_ctrl.set_pins(1'b0, 1'b0);
        i_ctrl.mr_write(ADDR_TERM_OVR, 8'h33);
        term_chk(7'b0100111, 7'h65);
        // Write copy 1 while operating on copy 0, then switch
        i_ctrl.mr_write(ADDR_SET_POINT, 8'h40);
        i_ctrl.mr_write(ADDR_TERM_VALUE, 8'h20);
        i_ctrl.mr_write(ADDR_TERM_OVR, 8'h15);
        i_ctrl.mr_write(ADDR_DQ_REF, 8'h72);
        rd_chk(ADDR_DQ_REF, 8'h72);
        term_chk(7'b0100111, 7'h65);
        i_ctrl.mr_write(ADDR_SET_POINT, 8'hC0);
        term_chk(7'b0101011, 7'h4D);
        chk("dq_ref", 32'h72, {25'h0, dq_ref_active});
        report_and_stop();
    end
endmodule

// [sim/mrb_ctrl_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Controller model issuing mode register commands
// ----------------------------------------
module mrb_ctrl_model
    import mrb_pkg::*;
(
    input wire logic mclk,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    output mrb_req_t req,
    output logic osc_start,
    output logic [15:0] osc_count,
    output logic osc_valid,
    output logic cal_start,
    output logic ca_term_pad,
    output logic ch_sel
);
    // Idle state at time zero
    initial begin
        req = '0;
        {osc_start, osc_valid, cal_start, ca_term_pad, ch_sel} = '0;
        osc_count = '0;
    end
    // Write: held one edge, released lines show inverted values
    task automatic mr_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge mclk);
        req <= '{1'b0, 1'b0, ~a, ~d};
    endtask
    // Read: answer sampled 1 ns after the taking edge
    task automatic mr_read(input logic [7:0] a, output logic [8:0] r);
        @(posedge mclk);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge mclk);
        req <= '{1'b0, 1'b0, ~a, 8'hFF};
        #1;
        r = {rd_valid, rd_data};
    endtask
    // Both count bytes read and joined
    task automatic osc_read(output logic [15:0] c);
        logic [8:0] lo;
        logic [8:0] hi;
        mr_read(ADDR_OSC_LOW, lo);
        mr_read(ADDR_OSC_HIGH, hi);
        c = {hi[7:0], lo[7:0]};
    endtask
    // Oscillator count load from the strobe counter
    task automatic osc_load(input logic [15:0] c);
        @(posedge mclk);
        osc_count <= c;
        osc_valid <= 1'b1;
        @(posedge mclk);
        osc_valid <= 1'b0;
        osc_count <= ~c;
    endtask
    // Single-cycle command pulses
    task automatic pulse(input logic is_cal);
        @(posedge mclk);
        if (is_cal) begin
            cal_start <= 1'b1;
        end else begin
            osc_start <= 1'b1;
        end
        @(posedge mclk);
        cal_start <= 1'b0;
        osc_start <= 1'b0;
    endtask
    // Channel select and pad level
    task automatic set_pins(input logic ch, input logic pad);
        @(posedge mclk);
        ch_sel <= ch;
        ca_term_pad <= pad;
    endtask
endmodule
